// [include/bvs_params.svh]
// Constants for the buck enable and output-voltage setpoint block.
// Assumes a 10 MHz core clock and millivolt-coded monitor inputs.
`ifndef BVS_PARAMS_SVH
`define BVS_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BVS_CLK_PERIOD_NS   100
`define BVS_DEGLITCH_NS     200
`define BVS_DEGLITCH_CYC    ((`BVS_DEGLITCH_NS + `BVS_CLK_PERIOD_NS - 1) / `BVS_CLK_PERIOD_NS)
`define BVS_INIT_US         200
`define BVS_INIT_CYC        ((`BVS_INIT_US * 1000 + `BVS_CLK_PERIOD_NS - 1) / `BVS_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Lockout thresholds in millivolts
// ----------------------------------------------------------------------
`define BVS_BIAS_ON_MV      16'd3150
`define BVS_BIAS_OFF_MV     16'd3100
`define BVS_DRV_ON_MV       16'd3600
`define BVS_DRV_OFF_MV      16'd3400
`define BVS_EN_HIGH_MV      16'd1200
`define BVS_EN_LOW_MV       16'd1000

// ----------------------------------------------------------------------
// Voltage codes, 1.953 mV per LSB, margins in units of 1/1024
// ----------------------------------------------------------------------
`define BVS_VOUT_ABS_MIN    12'd128
`define BVS_VOUT_ABS_MAX    12'd2816
`define BVS_DAC_MIN         12'd128
`define BVS_DAC_MAX         12'd384
`define BVS_EXT_BOOT        12'd205
`define BVS_MARGIN_ONE      17'sd1024
`define BVS_MARGIN_SHIFT    10

// ----------------------------------------------------------------------
// Register indices and reset values
// ----------------------------------------------------------------------
`define BVS_REG_OPERATION   8'h00
`define BVS_REG_VIN_ON      8'h01
`define BVS_REG_VIN_OFF     8'h02
`define BVS_REG_VOUT_CMD    8'h03
`define BVS_REG_VOUT_TRIM   8'h04
`define BVS_REG_MARGIN_HI   8'h05
`define BVS_REG_MARGIN_LO   8'h06
`define BVS_REG_VOUT_MODE   8'h07
`define BVS_REG_VOUT_MAX    8'h08
`define BVS_REG_VOUT_MIN    8'h09
`define BVS_REG_SCALE_LOOP  8'h0A
`define BVS_REG_BOOT        8'h0B
`define BVS_REG_USER_CFG    8'h0C
`define BVS_REG_TRANS_RATE  8'h0D
`define BVS_REG_STATUS      8'h0E
`define BVS_REG_TARGET      8'h0F

`define BVS_OP_MARGIN_HI_BIT 5
`define BVS_OP_MARGIN_LO_BIT 4
`define BVS_MODE_REL_BIT     7
`define BVS_CFG_ORST_BIT     2

`define BVS_RST_VIN_ON      16'd4200
`define BVS_RST_VIN_OFF     16'd4000
`define BVS_RST_MARGIN_HI   16'd1075
`define BVS_RST_MARGIN_LO   16'd973
`define BVS_RST_VOUT_MODE   8'h80
`define BVS_RST_VOUT_MAX    12'd2816
`define BVS_RST_VOUT_MIN    12'd128
`define BVS_RST_TRANS_RATE  16'd10

`endif

// [include/bvs_pkg.sv]
// Types for the buck enable and output-voltage setpoint block.
// Assumes bvs_params.svh holds every number.
package bvs_pkg;

  // Gray-coded start-up sequence: lockout, initialise, ready.
  typedef enum logic [1:0] {
    BVS_LOCKED = 2'b00,
    BVS_INIT   = 2'b01,
    BVS_READY  = 2'b11
  } bvs_state_t;

endpackage

// [rtl/bvs_core.sv]
// Enable gating and output-voltage setpoint for a point-of-load buck.
// Assumes millivolt monitor codes synchronous to clock and a plain register port.
// Behaviour
// - Switching only with all four lockouts met; bias alone opens telemetry, bus also waits for initialisation.
// - Bias good above 3.15V, lost below 3.1V; starts core and strap capture.
// - Driver supply enables conversion above 3.6V, disables below 3.4V.
// - Input rail compared with separately programmed turn-on and turn-off levels.
// - Turn-off above turn-on makes the rail qualifier toggle while between turn-on and turn-off.
// - Enable pin turns on above 1.2V and off below 1V.
// - Enable pin changes shorter than 0.2us are ignored.
// - A floating, pulled-down enable pin keeps the converter disabled.
// - Internal or external feedback divider chosen by the first multi-select strap.
// - External divider: reference boots at 0.4V with unity loop gain.
// - Internal divider: setpoint decoded from the voltage-select resistor code.
// - Commanded voltage drives the reference DAC over 0.25V to 0.75V.
// - Loop scale selects divider gain 1, 0.5, 0.25 or 0.125.
// - Target is command plus trim plus margin terms gated by operation bits 5, 4.
// - One code step is 1.953mV.
// - Target limited by max and min registers within 0.25V to 5.5V.
// - Margins default to relative format through mode bit 7.
// - Output reset pin low with config bit 2 ramps command to boot voltage.
// - About 200us of initialisation before bus reads and writes are accepted.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`include "bvs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module bvs_core (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Monitor codes in millivolts
  input  wire logic [15:0] bias_supply_mv,
  input  wire logic [15:0] driver_supply_mv,
  input  wire logic [15:0] power_input_rail_mv,
  input  wire logic [15:0] enable_pin_mv,
  // Straps and pins
  input  wire logic [2:0]  first_multi_select_strap,
  input  wire logic [2:0]  voltage_select_feedback_pin,
  input  wire logic        output_reset_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // Converter controls
  output logic             switching_enable,
  output logic             bus_enable,
  output logic             telemetry_enable,
  output logic             external_feedback,
  output logic      [1:0]  loop_scale,
  output logic      [11:0] dac_code,
  output logic      [11:0] target_vout
);

  localparam int INIT_CYC = `BVS_INIT_CYC;
  localparam int DGL_CYC  = `BVS_DEGLITCH_CYC;
  // Boot code and loop scale for each internal-divider resistor code.
  localparam logic [11:0] STRAP_BOOT [8] = '{12'd256, 12'd307, 12'd384, 12'd461,
                                             12'd512, 12'd614, 12'd922, 12'd1690};
  localparam logic [1:0]  STRAP_SCALE [8] = '{2'd0, 2'd0, 2'd0, 2'd1,
                                              2'd1, 2'd1, 2'd2, 2'd3};

  // ----------------------------------------------------------------------
  // Lockout comparators with hysteresis
  // ----------------------------------------------------------------------
  logic bias_ok;
  logic drv_ok;
  logic rail_ok;
  logic en_filt;
  logic [1:0] dgl_cnt;
  logic [15:0] vin_on;
  logic [15:0] vin_off;

  wire next_bias_ok = bias_ok ? !(bias_supply_mv < `BVS_BIAS_OFF_MV)
                              : (bias_supply_mv > `BVS_BIAS_ON_MV);
  wire next_drv_ok  = drv_ok ? !(driver_supply_mv < `BVS_DRV_OFF_MV)
                             : (driver_supply_mv > `BVS_DRV_ON_MV);
  // With the off level above the on level this flips every cycle while the rail sits between them, as the silicon does.
  wire next_rail_ok = rail_ok ? !(power_input_rail_mv < vin_off)
                              : (power_input_rail_mv > vin_on);
  // A floating pin reads as 0 mV and never passes the high threshold.
  wire en_cand      = en_filt ? !(enable_pin_mv < `BVS_EN_LOW_MV)
                              : (enable_pin_mv > `BVS_EN_HIGH_MV);
  wire en_differs   = en_cand != en_filt;
  wire en_accept    = en_differs && (32'(dgl_cnt) == DGL_CYC - 1);

  always_ff @(posedge clock) begin
    if (reset) begin
      bias_ok <= 1'b0;
      drv_ok  <= 1'b0;
      rail_ok <= 1'b0;
      en_filt <= 1'b0;
      dgl_cnt <= 2'd0;
    end else begin
      bias_ok <= next_bias_ok;
      drv_ok  <= next_drv_ok;
      rail_ok <= next_rail_ok;
      en_filt <= en_accept ? en_cand : en_filt;
      dgl_cnt <= (en_differs && !en_accept) ? dgl_cnt + 2'd1 : 2'd0;
    end
  end

  // ----------------------------------------------------------------------
  // Start-up sequence and strap capture
  // ----------------------------------------------------------------------
  bvs_pkg::bvs_state_t state;
  bvs_pkg::bvs_state_t next_state;
  logic [10:0] init_cnt;
  logic [2:0]  strap_msel;
  logic [2:0]  strap_vsel;

  wire init_done  = (32'(init_cnt) == INIT_CYC - 1);
  wire capture    = (state == bvs_pkg::BVS_LOCKED) && bias_ok;
  wire ready      = (state == bvs_pkg::BVS_READY);

  always_comb begin
    case (state)
      bvs_pkg::BVS_LOCKED: next_state = bias_ok ? bvs_pkg::BVS_INIT : bvs_pkg::BVS_LOCKED;
      bvs_pkg::BVS_INIT:   next_state = init_done ? bvs_pkg::BVS_READY : bvs_pkg::BVS_INIT;
      bvs_pkg::BVS_READY:  next_state = bvs_pkg::BVS_READY;
      default:             next_state = bvs_pkg::BVS_LOCKED;
    endcase
    if (!bias_ok) begin
      next_state = bvs_pkg::BVS_LOCKED;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state      <= bvs_pkg::BVS_LOCKED;
      init_cnt   <= 11'd0;
      strap_msel <= 3'd0;
      strap_vsel <= 3'd0;
    end else begin
      state    <= next_state;
      init_cnt <= (state == bvs_pkg::BVS_INIT) ? init_cnt + 11'd1 : 11'd0;
      if (capture) begin
        strap_msel <= first_multi_select_strap;
        strap_vsel <= voltage_select_feedback_pin;
      end
    end
  end

  wire ext_fb     = strap_msel[0];
  // At capture the strap registers are still being loaded, so decode the pins directly.
  wire ext_now = first_multi_select_strap[0];
  wire [11:0] strap_boot_now  = ext_now ? `BVS_EXT_BOOT
                                        : STRAP_BOOT[voltage_select_feedback_pin];
  wire [1:0]  strap_scale_now = ext_now ? 2'd0 : STRAP_SCALE[voltage_select_feedback_pin];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  operation;
  logic [11:0] vout_command;
  logic [15:0] vout_trim;
  logic [15:0] margin_high;
  logic [15:0] margin_low;
  logic [7:0]  vout_mode;
  logic [11:0] vout_max;
  logic [11:0] vout_min;
  logic [1:0]  scale_loop;
  logic [11:0] stored_boot_voltage;
  logic [7:0]  user_system_config;
  logic [15:0] transition_rate;
  logic [15:0] rate_cnt;

  // Bus traffic is refused until initialisation ends.
  wire wr_ok = reg_write && ready;
  wire rd_ok = reg_read && ready;
  wire wr_cmd = wr_ok && (reg_addr == `BVS_REG_VOUT_CMD);

  // Output reset ramps the command to boot one code per rate period.
  wire orst_active = ready && !output_reset_n
                     && user_system_config[`BVS_CFG_ORST_BIT];
  wire rate_tick   = orst_active && (rate_cnt >= transition_rate);
  wire at_boot     = (vout_command == stored_boot_voltage);
  wire [11:0] ramp_cmd = (vout_command < stored_boot_voltage) ? vout_command + 12'd1
                                                             : vout_command - 12'd1;

  always_ff @(posedge clock) begin
    if (reset || capture) begin
      operation           <= 8'h00;
      vin_on              <= `BVS_RST_VIN_ON;
      vin_off             <= `BVS_RST_VIN_OFF;
      vout_trim           <= 16'h0000;
      margin_high         <= `BVS_RST_MARGIN_HI;
      margin_low          <= `BVS_RST_MARGIN_LO;
      vout_mode           <= `BVS_RST_VOUT_MODE;
      vout_max            <= `BVS_RST_VOUT_MAX;
      vout_min            <= `BVS_RST_VOUT_MIN;
      user_system_config  <= 8'h00;
      transition_rate     <= `BVS_RST_TRANS_RATE;
    end else if (wr_ok) begin
      case (reg_addr)
        `BVS_REG_OPERATION:  operation          <= reg_wdata[7:0];
        `BVS_REG_VIN_ON:     vin_on             <= reg_wdata;
        `BVS_REG_VIN_OFF:    vin_off            <= reg_wdata;
        `BVS_REG_VOUT_TRIM:  vout_trim          <= reg_wdata;
        `BVS_REG_MARGIN_HI:  margin_high        <= reg_wdata;
        `BVS_REG_MARGIN_LO:  margin_low         <= reg_wdata;
        `BVS_REG_VOUT_MODE:  vout_mode          <= reg_wdata[7:0];
        `BVS_REG_VOUT_MAX:   vout_max           <= reg_wdata[11:0];
        `BVS_REG_VOUT_MIN:   vout_min           <= reg_wdata[11:0];
        `BVS_REG_USER_CFG:   user_system_config <= reg_wdata[7:0];
        `BVS_REG_TRANS_RATE: transition_rate    <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Strap-derived values load at capture and stay writable afterwards, loop scale only with the internal divider.
  always_ff @(posedge clock) begin
    if (reset) begin
      vout_command        <= 12'd0;
      stored_boot_voltage <= 12'd0;
      scale_loop          <= 2'd0;
      rate_cnt            <= 16'h0000;
    end else if (capture) begin
      vout_command        <= strap_boot_now;
      stored_boot_voltage <= strap_boot_now;
      scale_loop          <= strap_scale_now;
      rate_cnt            <= 16'h0000;
    end else begin
      rate_cnt <= (orst_active && !rate_tick) ? rate_cnt + 16'h0001 : 16'h0000;
      if (wr_cmd) begin
        vout_command <= reg_wdata[11:0];
      end else if (rate_tick && !at_boot) begin
        vout_command <= ramp_cmd;
      end
      if (wr_ok && reg_addr == `BVS_REG_BOOT) begin
        stored_boot_voltage <= reg_wdata[11:0];
      end
      if (wr_ok && reg_addr == `BVS_REG_SCALE_LOOP && !ext_fb) begin
        scale_loop <= reg_wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Target voltage arithmetic
  // ----------------------------------------------------------------------
  wire relative = vout_mode[`BVS_MODE_REL_BIT];
  wire op_hi    = operation[`BVS_OP_MARGIN_HI_BIT];
  wire op_lo    = operation[`BVS_OP_MARGIN_LO_BIT];
  wire signed [16:0] mh_delta = $signed({1'b0, margin_high}) - `BVS_MARGIN_ONE;
  wire signed [16:0] ml_delta = `BVS_MARGIN_ONE - $signed({1'b0, margin_low});
  wire signed [29:0] hi_prod  = mh_delta * $signed({1'b0, vout_command});
  wire signed [29:0] lo_prod  = ml_delta * $signed({1'b0, vout_command});
  wire signed [31:0] hi_term  = {{12{hi_prod[29]}}, hi_prod[29:`BVS_MARGIN_SHIFT]};
  wire signed [31:0] lo_term  = {{12{lo_prod[29]}}, lo_prod[29:`BVS_MARGIN_SHIFT]};
  wire signed [31:0] trim_s   = {{16{vout_trim[15]}}, vout_trim};
  wire signed [31:0] base_s   = (relative || !(op_hi || op_lo))
                                ? $signed({20'h00000, vout_command})
                                : $signed({16'h0000, op_hi ? margin_high : margin_low});
  wire signed [31:0] raw_vout = base_s + trim_s
                                + ((relative && op_hi) ? hi_term : 32'sh0)
                                - ((relative && op_lo) ? lo_term : 32'sh0);
  wire [11:0] lim_hi = (vout_max > `BVS_VOUT_ABS_MAX) ? `BVS_VOUT_ABS_MAX : vout_max;
  wire [11:0] lim_lo = (vout_min < `BVS_VOUT_ABS_MIN) ? `BVS_VOUT_ABS_MIN : vout_min;
  wire [11:0] next_target = (raw_vout > $signed({20'h00000, lim_hi})) ? lim_hi
                          : (raw_vout < $signed({20'h00000, lim_lo})) ? lim_lo
                          : raw_vout[11:0];
  wire [1:0]  eff_scale = ext_fb ? 2'd0 : scale_loop;
  wire [11:0] scaled    = next_target >> eff_scale;
  wire [11:0] next_dac  = (scaled < `BVS_DAC_MIN) ? `BVS_DAC_MIN
                        : (scaled > `BVS_DAC_MAX) ? `BVS_DAC_MAX : scaled;

  always_ff @(posedge clock) begin
    if (reset) begin
      target_vout <= 12'd0;
      dac_code    <= `BVS_DAC_MIN;
      loop_scale  <= 2'd0;
    end else begin
      target_vout <= next_target;
      dac_code    <= next_dac;
      loop_scale  <= eff_scale;
    end
  end

  // ----------------------------------------------------------------------
  // Enables and read-back
  // ----------------------------------------------------------------------
  // Combinational so that any lost condition stops switching in the same cycle.
  assign switching_enable = bias_ok && drv_ok && rail_ok && en_filt;
  assign bus_enable       = ready;
  assign telemetry_enable = bias_ok;
  assign external_feedback = ext_fb;

  wire [15:0] status_word = {8'h00, orst_active, ext_fb, ready, switching_enable,
                             en_filt, rail_ok, drv_ok, bias_ok};
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `BVS_REG_OPERATION:  rd_mux = {8'h00, operation};
      `BVS_REG_VIN_ON:     rd_mux = vin_on;
      `BVS_REG_VIN_OFF:    rd_mux = vin_off;
      `BVS_REG_VOUT_CMD:   rd_mux = {4'h0, vout_command};
      `BVS_REG_VOUT_TRIM:  rd_mux = vout_trim;
      `BVS_REG_MARGIN_HI:  rd_mux = margin_high;
      `BVS_REG_MARGIN_LO:  rd_mux = margin_low;
      `BVS_REG_VOUT_MODE:  rd_mux = {8'h00, vout_mode};
      `BVS_REG_VOUT_MAX:   rd_mux = {4'h0, vout_max};
      `BVS_REG_VOUT_MIN:   rd_mux = {4'h0, vout_min};
      `BVS_REG_SCALE_LOOP: rd_mux = {14'h0000, scale_loop};
      `BVS_REG_BOOT:       rd_mux = {4'h0, stored_boot_voltage};
      `BVS_REG_USER_CFG:   rd_mux = {8'h00, user_system_config};
      `BVS_REG_TRANS_RATE: rd_mux = transition_rate;
      `BVS_REG_STATUS:     rd_mux = status_word;
      `BVS_REG_TARGET:     rd_mux = {4'h0, target_vout};
      default:             rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rd_ok ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sw_gating_a: assert property (switching_enable |-> $past(bias_supply_mv) >= `BVS_BIAS_OFF_MV
                                && $past(driver_supply_mv) >= `BVS_DRV_OFF_MV)
    else $error("switching while a lockout is not met");
  bias_on_a: assert property (!bias_ok && bias_supply_mv > `BVS_BIAS_ON_MV |=> bias_ok)
    else $error("bias good did not assert");
  drv_off_a: assert property (drv_ok && driver_supply_mv < `BVS_DRV_OFF_MV |=> !drv_ok)
    else $error("driver lockout did not engage");
  rail_toggle_a: assert property (rail_ok && power_input_rail_mv < vin_off |=> !rail_ok)
    else $error("rail qualifier missed turn-off level");
  en_glitch_a: assert property ($rose(en_filt) |-> $past(en_cand) && $past(en_cand, 2))
    else $error("enable accepted a short pulse");
  en_float_a: assert property (enable_pin_mv == 16'h0000 [*2] |=> !en_filt)
    else $error("floating enable pin enabled switching");
  init_len_a: assert property ($rose(state == bvs_pkg::BVS_INIT) |-> !ready [*8])
    else $error("bus opened too early");
  dac_range_a: assert property (dac_code >= `BVS_DAC_MIN && dac_code <= `BVS_DAC_MAX)
    else $error("reference code out of range");
  vout_span_a: assert property (target_vout <= `BVS_VOUT_ABS_MAX)
    else $error("target above absolute span");
  ext_scale_a: assert property (ext_fb |=> loop_scale == 2'd0)
    else $error("external divider with non-unity gain");
  strap_hold_a: assert property (state != bvs_pkg::BVS_LOCKED && bias_ok |=> $stable(strap_msel))
    else $error("strap changed without lockout");
  sw_drop_a: assert property (switching_enable && !next_drv_ok |=> !switching_enable)
    else $error("switching outlived driver lockout");
  orst_move_a: assert property (rate_tick && !at_boot && !wr_cmd |=> vout_command != $past(vout_command))
    else $error("output reset did not step command");

  sw_on_c: cover property ($rose(switching_enable));
  ready_c: cover property ($rose(ready));
  orst_c:  cover property (orst_active && at_boot);
  margin_c: cover property (relative && op_hi && target_vout > vout_command);

endmodule

`default_nettype wire

// [verification/bvs_board.sv]
// Board-side model of the enable pin, with its internal pull-down.
// Assumes the bench asks for a driven level through en_drive and en_high.
`timescale 1ns/1ps
`default_nettype none
module bvs_board (
  // Requests from the bench
  input  wire logic        en_drive,
  input  wire logic        en_high,
  // Pin level in millivolts
  output logic      [15:0] enable_pin_mv
);
  // An undriven pin sits at ground through the pull-down.
  assign enable_pin_mv = en_drive ? (en_high ? 16'h0514 : 16'h0320) : 16'h0000;
endmodule
`default_nettype wire

// [verification/tb_buck_enable_and_vout_setpoint.sv]
// Self-checking bench for the enable gating and output-voltage setpoint block.
// Assumes the design constants in bvs_params.svh and a 100 ns clock.
`include "bvs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_buck_enable_and_vout_setpoint;
  logic        clock, reset, en_drive, en_high, orst_n, wr_s, rd_s, sw, bus, tel, ext, sw_prev;
  logic [2:0]  vsel;
  logic [13:0] es;
  logic [15:0] bias, drv, rail, pin, wdat, rdat, cmd;
  logic [7:0]  addr;
  logic [2:0]  strap;
  logic [1:0]  scale;
  logic [11:0] dac, tgt;
  int          n_mismatch, n_checks, cyc;
  bvs_board u_board (.en_drive(en_drive), .en_high(en_high), .enable_pin_mv(pin));
  bvs_core u_dut (.clock(clock), .reset(reset), .bias_supply_mv(bias), .driver_supply_mv(drv),
    .power_input_rail_mv(rail), .enable_pin_mv(pin), .first_multi_select_strap(strap),
    .voltage_select_feedback_pin(vsel), .output_reset_n(orst_n), .reg_addr(addr),
    .reg_wdata(wdat), .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdat),
    .switching_enable(sw), .bus_enable(bus), .telemetry_enable(tel),
    .external_feedback(ext), .loop_scale(scale), .dac_code(dac), .target_vout(tgt));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1;
    chk(rdat, exp);
  endtask
  task automatic wait_bus();
    for (int i = 0; i < 3000 && bus !== 1'b1; i++) cycles(1);
  endtask
  // Relative margins: 1075 and 973 are 1024 plus and minus 51.
  function automatic logic [15:0] exp_tgt(input logic [15:0] c, input logic [1:0] op);
    logic [15:0] t;
    t = c + (op[1] ? (16'd51 * c) >> 10 : 16'd0) - (op[0] ? (16'd51 * c) >> 10 : 16'd0);
    return (t > 16'd2816) ? 16'd2816 : ((t < 16'd128) ? 16'd128 : t);
  endfunction
  // Loop scale and boot code expected for each internal-divider resistor code.
  function automatic logic [13:0] exp_strap(input logic [2:0] v);
    logic [11:0] boot [8];
    boot = '{12'd256, 12'd307, 12'd384, 12'd461, 12'd512, 12'd614, 12'd922, 12'd1690};
    return {(v < 3'd3) ? 2'd0 : (v < 3'd6) ? 2'd1 : (v == 3'd6) ? 2'd2 : 2'd3, boot[v]};
  endfunction
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    {reset, en_drive, en_high, wr_s, rd_s, orst_n} = 6'b101001;
    {bias, drv, rail, wdat, addr, strap, vsel} = '0;
    {cyc, n_mismatch, n_checks} = '0;
    void'($urandom(89));
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    bias <= 16'd3300;
    drv <= 16'd3700;
    rail <= 16'd5000;
    cycles(5);
    chk(tel, 1);
    chk(sw, 0);
    @(posedge clock) en_drive <= 1'b1;
    wr(`BVS_REG_VIN_ON, 16'd100);
    rd(`BVS_REG_STATUS, 0);
    while (cyc < 1990) cycles(1);
    chk(bus, 0);
    wait_bus();
    chk(cyc < 2030, 1);
    rd(`BVS_REG_VIN_ON, 16'd4200);
    rd(`BVS_REG_VOUT_MODE, 16'h0080);
    rd(8'h3C, 0);
    chk({sw, ext, 2'(scale), 12'(tgt)}, {4'h8, 12'd256});
    @(posedge clock) drv <= 16'd3500;
    cycles(3);
    chk(sw, 1);
    @(posedge clock) drv <= 16'd3300;
    cycles(2);
    chk(sw, 0);
    drv <= 16'd3700;
    wr(`BVS_REG_VIN_ON, 16'd4500);
    wr(`BVS_REG_VIN_OFF, 16'd4300);
    @(posedge clock) rail <= 16'd4400;
    cycles(3);
    chk(sw, 1);
    @(posedge clock) rail <= 16'd4200;
    cycles(2);
    chk(sw, 0);
    @(posedge clock) rail <= 16'd4400;
    cycles(3);
    chk(sw, 0);
    wr(`BVS_REG_VIN_ON, 16'd4000);
    wr(`BVS_REG_VIN_OFF, 16'd4600);
    cycles(2);
    sw_prev = sw;
    cycles(1);
    chk(sw, !sw_prev);
    @(posedge clock) rail <= 16'd5000;
    @(posedge clock) en_drive <= 1'b0;
    @(posedge clock) en_drive <= 1'b1;
    repeat (4) begin
      cycles(1);
      chk(sw, 1);
    end
    @(posedge clock) en_drive <= 1'b0;
    cycles(3);
    chk(sw, 0);
    @(posedge clock) en_drive <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      cmd = 16'd128 + 16'($urandom_range(256));
      wr(`BVS_REG_VOUT_CMD, cmd);
      wr(`BVS_REG_OPERATION, 16'(i % 4) << 4);
      cycles(3);
      chk({4'h0, tgt}, exp_tgt(cmd, 2'(i % 4)));
      chk(dac >= 12'd128 && dac <= 12'd384, 1);
    end
    wr(`BVS_REG_OPERATION, 0);
    wr(`BVS_REG_VOUT_CMD, 16'd300);
    wr(`BVS_REG_VOUT_TRIM, 16'hFFF6);
    rd(`BVS_REG_TARGET, 16'd290);
    wr(`BVS_REG_VOUT_MAX, 16'd200);
    rd(`BVS_REG_TARGET, 16'd200);
    wr(`BVS_REG_VOUT_MAX, 16'd2816);
    wr(`BVS_REG_VOUT_TRIM, 0);
    wr(`BVS_REG_USER_CFG, 16'h0004);
    @(posedge clock) orst_n <= 1'b0;
    cycles(44 * 11 + 20);
    chk({4'h0, tgt}, 16'd256);
    @(posedge clock) orst_n <= 1'b1;
    strap <= 3'h1;
    bias <= 16'd3120;
    cycles(3);
    chk({tel, ext}, 2'b10);
    @(posedge clock) bias <= 16'd3000;
    cycles(2);
    chk({tel, sw, bus}, 0);
    bias <= 16'd3300;
    wait_bus();
    chk({ext, 2'(scale), 12'(dac)}, {3'h4, 12'd205});
    @(posedge clock) bias <= 16'd3000;
    strap <= 3'h0;
    vsel <= 3'($urandom_range(7));
    cycles(3);
    bias <= 16'd3300;
    wait_bus();
    es = exp_strap(vsel);
    chk({ext, scale, tgt}, {1'b0, es});
    chk({4'h0, dac}, {4'h0, es[11:0] >> es[13:12]});
    end_of_test();
  end
endmodule
`default_nettype wire
